// ==== rtl/pwm_pkg.sv ====
// Constants, register map and types shared by the modulator bank.
package pwm_pkg;

  localparam int NUM_CH = 4;
  localparam int CNT_W = 32;
  localparam int RPT_W = 8;
  localparam int ADR_W = 8;

  // Channel registers sit at channel * CH_STRIDE, global ones above GLOBAL_BIT.
  localparam logic [ADR_W-1:0] CH_STRIDE = 8'h20;
  localparam int GLOBAL_BIT = 7;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_CMD = 3'h1;
  localparam logic [2:0] REG_PERIOD = 3'h2;
  localparam logic [2:0] REG_DURATION = 3'h3;
  localparam logic [2:0] REG_REPEAT = 3'h4;
  localparam logic [2:0] REG_COUNT = 3'h5;
  localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 8'h80;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h84;

  // Control register fields.
  localparam int CTRL_ONESHOT = 0;
  localparam int CTRL_IDLE_LEVEL = 1;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_TRIG_FALLING = 4;
  localparam int CTRL_W = 5;

  // Command register fields; reading it returns the status fields.
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int STAT_RUNNING = 0;
  localparam int STAT_OUTPUT = 1;

  // Interrupt status: low nibble period end, high nibble run done.
  localparam int IRQ_PERIOD_LSB = 0;
  localparam int IRQ_DONE_LSB = 4;
  localparam int IRQ_W = 8;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 32'h00000000;
  localparam logic [CNT_W-1:0] DURATION_RESET = 32'h00000000;
  localparam logic [RPT_W-1:0] REPEAT_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 8'h00;

  typedef enum logic [1:0] {TRIG_SOFTWARE, TRIG_HW_EVENT, TRIG_CAM_VSYNC, TRIG_NONE} trig_src_t;
  typedef enum {ST_IDLE, ST_RUN} run_state_t;

endpackage : pwm_pkg

// ==== rtl/pwm_channel.sv ====
// One modulator channel: period counter, phase compare and run control.
module pwm_channel #(
  parameter int CW = 32,
  parameter int RW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic oneshot,
  input wire logic idle_level,
  input wire logic [1:0] trig_src,
  input wire logic trig_falling,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic hw_event,
  input wire logic cam_vsync,
  input wire logic [CW-1:0] period_shadow,
  input wire logic [CW-1:0] duration_shadow,
  input wire logic [RW-1:0] repeat_count,
  output logic pwm_out,
  output logic running,
  output logic [CW-1:0] count,
  output logic period_end,
  output logic run_done
);

  pwm_pkg::run_state_t state;
  pwm_pkg::run_state_t next_state;
  logic trig_prev;
  logic [CW-1:0] period_act;
  logic [CW-1:0] duration_act;
  logic [RW-1:0] left;
  logic [CW-1:0] next_count;
  logic [CW-1:0] next_period;
  logic [CW-1:0] next_duration;
  logic [RW-1:0] next_left;
  logic next_period_end;
  logic next_run_done;
  logic next_pwm;

  wire src_level = (trig_src == pwm_pkg::TRIG_HW_EVENT) ? hw_event : cam_vsync;
  wire rise = src_level & ~trig_prev;
  wire fall = ~src_level & trig_prev;
  wire hw_src = (trig_src == pwm_pkg::TRIG_HW_EVENT) || (trig_src == pwm_pkg::TRIG_CAM_VSYNC);
  wire hw_trig = hw_src & (trig_falling ? fall : rise);
  wire start = sw_start | hw_trig;
  // A period of zero behaves as one cycle so the counter can never run away.
  wire last = ({1'b0, count} + {{CW{1'b0}}, 1'b1}) >= {1'b0, period_act};
  wire finish = oneshot & (left == {RW{1'b0}});

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_period = period_act;
    next_duration = duration_act;
    next_left = left;
    next_period_end = 1'b0;
    next_run_done = 1'b0;
    case (state)
      pwm_pkg::ST_IDLE:
        if (start)
        begin
          next_state = pwm_pkg::ST_RUN;
          next_count = {CW{1'b0}};
          next_period = period_shadow;
          next_duration = duration_shadow;
          next_left = repeat_count;
        end
      pwm_pkg::ST_RUN:
        if (sw_stop)
        begin
          next_state = pwm_pkg::ST_IDLE;
          next_run_done = 1'b1;
        end
        else if (last)
        begin
          next_period_end = 1'b1;
          next_count = {CW{1'b0}};
          next_period = period_shadow;
          next_duration = duration_shadow;
          if (finish)
          begin
            next_state = pwm_pkg::ST_IDLE;
            next_run_done = 1'b1;
          end
          else if (oneshot)
            next_left = left - {{(RW-1){1'b0}}, 1'b1};
        end
        else
          next_count = count + {{(CW-1){1'b0}}, 1'b1};
      default:
        next_state = pwm_pkg::ST_IDLE;
    endcase
  end

  // First phase drives the opposite of the idle level, second phase the idle level.
  assign next_pwm = (next_state == pwm_pkg::ST_RUN && next_count < next_duration) ?
                    ~idle_level : idle_level;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= pwm_pkg::ST_IDLE;
      trig_prev <= 1'b0;
      count <= {CW{1'b0}};
      period_act <= {CW{1'b0}};
      duration_act <= {CW{1'b0}};
      left <= {RW{1'b0}};
      pwm_out <= 1'b0;
      period_end <= 1'b0;
      run_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      trig_prev <= src_level;
      count <= next_count;
      period_act <= next_period;
      duration_act <= next_duration;
      left <= next_left;
      pwm_out <= next_pwm;
      period_end <= next_period_end;
      run_done <= next_run_done;
    end
  end

  assign running = (state == pwm_pkg::ST_RUN);

endmodule : pwm_channel

// ==== rtl/pwm_bank.sv ====
// Bank of four modulator channels behind a classic Wishbone slave.
module pwm_bank #(
  parameter int NUM = pwm_pkg::NUM_CH
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [pwm_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [NUM-1:0] HW_EVENT,
  input wire logic CAMERA_VERTICAL_SYNC,
  output logic [NUM-1:0] MODULATOR_OUTPUT_PIN,
  output logic [NUM-1:0] DMA_SYNC_EVENT,
  output logic IRQ
);

  localparam int CW = pwm_pkg::CNT_W;
  localparam int RW = pwm_pkg::RPT_W;
  localparam int IW = pwm_pkg::IRQ_W;

  // The address map and interrupt layout have room for exactly four channels.
  if (NUM != pwm_pkg::NUM_CH)
  begin : g_num_check
    $error("pwm_bank supports exactly four channels");
  end

  // Merge a write into a stored word lane by lane.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = data[b*8 +: 8];
    end
    return res;
  endfunction : merge

  // Configuration storage, one set per channel.
  logic [pwm_pkg::CTRL_W-1:0] ctrl [NUM];
  logic [CW-1:0] period_sh [NUM];
  logic [CW-1:0] duration_sh [NUM];
  logic [RW-1:0] repeat_sh [NUM];
  logic [NUM-1:0] start_pulse;
  logic [NUM-1:0] stop_pulse;
  logic [IW-1:0] irq_status;
  logic [IW-1:0] irq_mask;

  // Two-stage synchronisers for the pins that come from other clock domains.
  logic [NUM-1:0] hw_meta;
  logic [NUM-1:0] hw_sync;
  logic vs_meta;
  logic vs_sync;

  // Channel outputs.
  logic [NUM-1:0] pwm_w;
  logic [NUM-1:0] running_w;
  logic [NUM-1:0] period_end_w;
  logic [NUM-1:0] done_w;
  logic [CW-1:0] count_w [NUM];

  // Bus decode.
  wire req = WB_CYC_I & WB_STB_I;
  wire wr_go = req & WB_WE_I & WB_ACK_O;
  wire is_global = WB_ADR_I[pwm_pkg::GLOBAL_BIT];
  wire [1:0] ch_sel = WB_ADR_I[6:5];
  wire [2:0] reg_sel = WB_ADR_I[4:2];
  wire word_ok = (WB_ADR_I[1:0] == 2'h0);
  wire hit_status = word_ok & (WB_ADR_I == pwm_pkg::OFS_IRQ_STATUS);
  wire hit_mask = word_ok & (WB_ADR_I == pwm_pkg::OFS_IRQ_MASK);
  wire ch_hit = word_ok & ~is_global;
  wire wr_ctrl = wr_go & ch_hit & (reg_sel == pwm_pkg::REG_CTRL);
  wire wr_cmd = wr_go & ch_hit & (reg_sel == pwm_pkg::REG_CMD);
  wire wr_period = wr_go & ch_hit & (reg_sel == pwm_pkg::REG_PERIOD);
  wire wr_duration = wr_go & ch_hit & (reg_sel == pwm_pkg::REG_DURATION);
  wire wr_repeat = wr_go & ch_hit & (reg_sel == pwm_pkg::REG_REPEAT);
  wire wr_status = wr_go & hit_status;
  wire wr_mask = wr_go & hit_mask;
  wire [31:0] cmd_word = merge(32'h00000000, WB_DAT_I, WB_SEL_I);
  // Narrow registers are widened to a word, merged, then cut back to their own width.
  wire [31:0] ctrl_word = merge({{(32-pwm_pkg::CTRL_W){1'b0}}, ctrl[ch_sel]}, WB_DAT_I,
                                WB_SEL_I);
  wire [31:0] repeat_word = merge({{(32-RW){1'b0}}, repeat_sh[ch_sel]}, WB_DAT_I, WB_SEL_I);

  // Interrupt events and write-one-to-clear; a new event beats a clear.
  wire [IW-1:0] irq_set = {done_w, period_end_w};
  wire [IW-1:0] irq_clr = wr_status ? cmd_word[IW-1:0] : {IW{1'b0}};
  wire [IW-1:0] next_status = (irq_status & ~irq_clr) | irq_set;
  wire [31:0] mask_word = merge({{(32-IW){1'b0}}, irq_mask}, WB_DAT_I, WB_SEL_I);

  // Read multiplexer.
  logic [31:0] ch_rdata;
  always_comb
  begin
    ch_rdata = 32'h00000000;
    case (reg_sel)
      pwm_pkg::REG_CTRL:
        ch_rdata[pwm_pkg::CTRL_W-1:0] = ctrl[ch_sel];
      pwm_pkg::REG_CMD:
      begin
        ch_rdata[pwm_pkg::STAT_RUNNING] = running_w[ch_sel];
        ch_rdata[pwm_pkg::STAT_OUTPUT] = pwm_w[ch_sel];
      end
      pwm_pkg::REG_PERIOD:
        ch_rdata = period_sh[ch_sel];
      pwm_pkg::REG_DURATION:
        ch_rdata = duration_sh[ch_sel];
      pwm_pkg::REG_REPEAT:
        ch_rdata[RW-1:0] = repeat_sh[ch_sel];
      pwm_pkg::REG_COUNT:
        ch_rdata = count_w[ch_sel];
      default:
        ch_rdata = 32'h00000000;
    endcase
  end

  // Unmapped addresses still answer, with zero, so the master never hangs.
  wire [31:0] rdata = ch_hit ? ch_rdata :
                      hit_status ? {{(32-IW){1'b0}}, irq_status} :
                      hit_mask ? {{(32-IW){1'b0}}, irq_mask} : 32'h00000000;

  // Acknowledge one cycle after the request; writes land on the acked edge.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= req & ~WB_ACK_O;
      WB_DAT_O <= (req & ~WB_ACK_O) ? rdata : 32'h00000000;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      hw_meta <= {NUM{1'b0}};
      hw_sync <= {NUM{1'b0}};
      vs_meta <= 1'b0;
      vs_sync <= 1'b0;
    end
    else
    begin
      hw_meta <= HW_EVENT;
      hw_sync <= hw_meta;
      vs_meta <= CAMERA_VERTICAL_SYNC;
      vs_sync <= vs_meta;
    end
  end

  // Software writes to period, duration and repeat only touch the shadow copies; ctrl acts at once.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < NUM; i++)
      begin
        ctrl[i] <= pwm_pkg::CTRL_RESET;
        period_sh[i] <= pwm_pkg::PERIOD_RESET;
        duration_sh[i] <= pwm_pkg::DURATION_RESET;
        repeat_sh[i] <= pwm_pkg::REPEAT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM; i++)
      begin
        if (ch_sel == 2'(i))
        begin
          if (wr_ctrl)
            ctrl[i] <= ctrl_word[pwm_pkg::CTRL_W-1:0];
          if (wr_period)
            period_sh[i] <= merge(period_sh[i], WB_DAT_I, WB_SEL_I);
          if (wr_duration)
            duration_sh[i] <= merge(duration_sh[i], WB_DAT_I, WB_SEL_I);
          if (wr_repeat)
            repeat_sh[i] <= repeat_word[RW-1:0];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      start_pulse <= {NUM{1'b0}};
      stop_pulse <= {NUM{1'b0}};
    end
    else
    begin
      for (int i = 0; i < NUM; i++)
      begin
        start_pulse[i] <= wr_cmd & (ch_sel == 2'(i)) & cmd_word[pwm_pkg::CMD_START];
        stop_pulse[i] <= wr_cmd & (ch_sel == 2'(i)) & cmd_word[pwm_pkg::CMD_STOP];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      irq_status <= pwm_pkg::IRQ_RESET;
      irq_mask <= pwm_pkg::IRQ_RESET;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      if (wr_mask)
        irq_mask <= mask_word[IW-1:0];
      IRQ <= |(next_status & (wr_mask ? mask_word[IW-1:0] : irq_mask));
    end
  end

  // Every channel has private state and an equal choice of trigger sources.
  for (genvar g = 0; g < NUM; g++)
  begin : g_ch
    pwm_channel #(
      .CW(CW),
      .RW(RW)
    ) u_channel (
      .clk(SYS_CLK),
      .nrst(NRST),
      .oneshot(ctrl[g][pwm_pkg::CTRL_ONESHOT]),
      .idle_level(ctrl[g][pwm_pkg::CTRL_IDLE_LEVEL]),
      .trig_src(ctrl[g][pwm_pkg::CTRL_TRIG_LSB +: 2]),
      .trig_falling(ctrl[g][pwm_pkg::CTRL_TRIG_FALLING]),
      .sw_start(start_pulse[g]),
      .sw_stop(stop_pulse[g]),
      .hw_event(hw_sync[g]),
      .cam_vsync(vs_sync),
      .period_shadow(period_sh[g]),
      .duration_shadow(duration_sh[g]),
      .repeat_count(repeat_sh[g]),
      .pwm_out(pwm_w[g]),
      .running(running_w[g]),
      .count(count_w[g]),
      .period_end(period_end_w[g]),
      .run_done(done_w[g])
    );
  end

  // Outputs are the channel flip-flops themselves.
  assign MODULATOR_OUTPUT_PIN = pwm_w;
  assign DMA_SYNC_EVENT = period_end_w;

endmodule : pwm_bank

// ==== rtl/pwm_bank_note_end.sv ====
// Holds no logic; the modulator bank lives in pwm_bank.sv.

// ==== verif/pwm_bank_chk.sv ====
// Concurrent checks on the ports of the modulator bank.
module pwm_bank_chk #(
  parameter int NUM = 4
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [pwm_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [NUM-1:0] HW_EVENT,
  input wire logic CAMERA_VERTICAL_SYNC,
  input wire logic [NUM-1:0] MODULATOR_OUTPUT_PIN,
  input wire logic [NUM-1:0] DMA_SYNC_EVENT,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  logic started;
  logic [NUM-1:0] mask;
  wire req = WB_CYC_I && WB_STB_I;
  wire wr = WB_ACK_O && WB_WE_I;
  wire wr_start = wr && !WB_ADR_I[pwm_pkg::GLOBAL_BIT] && WB_ADR_I[1:0] == 2'h0 &&
                  WB_ADR_I[4:2] == pwm_pkg::REG_CMD && WB_DAT_I[pwm_pkg::CMD_START];
  // The mask copy assumes full-word writes, which is all the bench issues.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      started <= 1'b0;
      mask <= '0;
    end
    else
    begin
      // Any high trigger pin counts, since a pin high at release looks like a rising edge.
      if (wr_start || HW_EVENT != '0 || CAMERA_VERTICAL_SYNC)
        started <= 1'b1;
      if (wr && WB_ADR_I == pwm_pkg::OFS_IRQ_MASK)
        mask <= WB_DAT_I[NUM-1:0];
    end
  end
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stood longer than one cycle");
  chk_ack_timing: assert property (req && !$past(req) |=> WB_ACK_O)
    else $error("request not acked in the next cycle");
  chk_ack_cause: assert property (WB_ACK_O |-> $past(req) && req)
    else $error("ack without a request");
  chk_data_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  chk_event_start: assert property (DMA_SYNC_EVENT != '0 |-> started)
    else $error("period event before any start");
  chk_irq_follow: assert property ((DMA_SYNC_EVENT & mask) != '0 && !wr |=> IRQ)
    else $error("enabled period event gave no interrupt");
  chk_irq_rise: assert property ($rose(IRQ) |-> $past(DMA_SYNC_EVENT) != '0
    || $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt fell without a write");
  cover property (DMA_SYNC_EVENT[0]);
  cover property ($rose(IRQ));
  cover property (WB_ACK_O && !WB_WE_I);
endmodule : pwm_bank_chk

bind pwm_bank pwm_bank_chk #(.NUM(NUM)) i_chk (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .HW_EVENT(HW_EVENT), .CAMERA_VERTICAL_SYNC(CAMERA_VERTICAL_SYNC),
  .MODULATOR_OUTPUT_PIN(MODULATOR_OUTPUT_PIN), .DMA_SYNC_EVENT(DMA_SYNC_EVENT), .IRQ(IRQ));

// ==== verif/pwm_partner.sv ====
// Far-side model: trigger sources and a pulse counter on channel 0.
module pwm_partner (
  input wire logic clk,
  input wire logic nrst,
  input wire logic strobe,
  input wire logic [3:0] ev_level,
  input wire logic vs_level,
  output logic [3:0] hw_event,
  output logic cam_vsync,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // Trigger lines move only on the clock, as a sensor timed from the same reference would.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hw_event <= 4'h0;
      cam_vsync <= 1'b0;
      last <= 1'b0;
      rises <= 0;
    end
    else
    begin
      hw_event <= ev_level;
      cam_vsync <= vs_level;
      last <= strobe;
      if (strobe && !last)
        rises <= rises + 1;
    end
  end
endmodule : pwm_partner

// ==== verif/pwm_bank_tb.sv ====
// Self-checking bench for the modulator bank.
module pwm_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h0;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [31:0] WB_DAT_O, rd;
  logic WB_ACK_O, CAMERA_VERTICAL_SYNC, IRQ;
  logic [3:0] HW_EVENT, MODULATOR_OUTPUT_PIN, DMA_SYNC_EVENT;
  logic [3:0] ev_level = 4'h0;
  logic vs_level = 1'b0;
  logic [31:0] hcnt = '0, win_high = '0, wins = '0, dma3 = '0, dma2 = '0;
  int rises, failures = 0, samples_checked = 0;
  always #10 SYS_CLK = ~SYS_CLK;
  pwm_bank i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .HW_EVENT(HW_EVENT),
    .CAMERA_VERTICAL_SYNC(CAMERA_VERTICAL_SYNC), .MODULATOR_OUTPUT_PIN(MODULATOR_OUTPUT_PIN),
    .DMA_SYNC_EVENT(DMA_SYNC_EVENT), .IRQ(IRQ));
  pwm_partner i_partner (.clk(SYS_CLK), .nrst(NRST), .strobe(MODULATOR_OUTPUT_PIN[0]),
    .ev_level(ev_level), .vs_level(vs_level), .hw_event(HW_EVENT),
    .cam_vsync(CAMERA_VERTICAL_SYNC), .rises(rises));
  // First-phase cycles of channel 0 between two period events.
  always @(posedge SYS_CLK)
  begin
    if (DMA_SYNC_EVENT[0] === 1'b1)
    begin
      win_high <= hcnt;
      hcnt <= {31'h0, MODULATOR_OUTPUT_PIN[0]};
      wins <= wins + 1'b1;
    end
    else
      hcnt <= hcnt + MODULATOR_OUTPUT_PIN[0];
    if (DMA_SYNC_EVENT[3] === 1'b1)
      dma3 <= dma3 + 1'b1;
    if (DMA_SYNC_EVENT[2] === 1'b1)
      dma2 <= dma2 + 1'b1;
  end
  task automatic print_verdict;
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge SYS_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'hF;
    WB_DAT_I <= d;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (WB_ACK_O !== 1'b1 && n < 20);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (WB_ACK_O !== 1'b1)
    begin
      failures++;
      print_verdict;
    end
  endtask : wb
  task automatic idle(input int c);
    repeat (c) @(posedge SYS_CLK);
  endtask : idle
  task automatic wait_win(input logic [31:0] w);
    int n;
    n = 0;
    while (wins < w && n < 200)
    begin
      @(posedge SYS_CLK);
      n++;
    end
  endtask : wait_win
  task automatic test_reset;
    logic [7:0] adr [6] = '{8'h00, 8'h48, 8'h70, 8'h80, 8'h84, 8'h18};
    check(MODULATOR_OUTPUT_PIN, 32'h0, "pins after reset");
    wb(1'b1, 8'h18, 32'hA5);
    foreach (adr[i])
    begin
      wb(1'b0, adr[i], 32'h0);
      check(rd, 32'h0, "reset or unmapped value");
    end
  endtask : test_reset
  task automatic test_idle;
    wb(1'b1, 8'h20, 32'h2);
    idle(3);
    check(MODULATOR_OUTPUT_PIN[1], 32'h1, "idle high pin");
    wb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h2, "idle pin status");
    wb(1'b1, 8'h4C, 32'hC0000001);
    wb(1'b0, 8'h4C, 32'h0);
    check(rd, 32'hC0000001, "wide duration");
  endtask : test_idle
  // Channel two runs continuously alone; channels zero and one must not move.
  task automatic test_channels;
    logic [31:0] d0;
    wb(1'b1, 8'h80, 32'hFF);
    wb(1'b1, 8'h48, 32'h3);
    wb(1'b1, 8'h4C, 32'h1);
    wb(1'b1, 8'h44, 32'h1);
    d0 = dma2;
    idle(30);
    check(dma2 - d0, 32'h9, "periods on channel two");
    check(MODULATOR_OUTPUT_PIN[1:0], 32'h2, "other channels idle");
    wb(1'b1, 8'h44, 32'h2);
    idle(3);
    wb(1'b0, 8'h80, 32'h0);
    check(rd, 32'h44, "channel two events");
  endtask : test_channels
  task automatic test_shadow;
    logic [31:0] w0;
    wb(1'b1, 8'h08, 32'h8);
    wb(1'b1, 8'h0C, 32'h4);
    wb(1'b1, 8'h04, 32'h1);
    w0 = wins;
    wait_win(w0 + 1);
    wb(1'b1, 8'h0C, 32'h1);
    wait_win(w0 + 2);
    check(win_high, 32'h4, "current period kept");
    wait_win(w0 + 3);
    check(win_high, 32'h1, "new duration at boundary");
    wb(1'b1, 8'h04, 32'h2);
    idle(3);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0, "stopped and idle");
    wb(1'b0, 8'h80, 32'h0);
    check(rd[4], 32'h1, "done after stop");
  endtask : test_shadow
  task automatic test_oneshot;
    int r0;
    logic [31:0] w0;
    wb(1'b1, 8'h80, 32'hFF);
    wb(1'b1, 8'h84, 32'h11);
    wb(1'b1, 8'h08, 32'h4);
    wb(1'b1, 8'h0C, 32'h2);
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h00, 32'h1);
    r0 = rises;
    w0 = wins;
    wb(1'b1, 8'h04, 32'h1);
    wait_win(w0 + 3);
    idle(20);
    check(rises - r0, 32'h3, "pulses in run");
    check(wins - w0, 32'h3, "periods in run");
    check(win_high, 32'h2, "duration loaded at start");
    check(MODULATOR_OUTPUT_PIN[0], 32'h0, "idle after run");
    check(IRQ, 32'h1, "interrupt raised");
    wb(1'b0, 8'h80, 32'h0);
    check(rd, 32'h11, "status after run");
    wb(1'b1, 8'h84, 32'h0);
    idle(2);
    check(IRQ, 32'h0, "interrupt masked");
    wb(1'b1, 8'h84, 32'h11);
    idle(2);
    check(IRQ, 32'h1, "interrupt unmasked");
    wb(1'b1, 8'h80, 32'hFF);
    idle(2);
    check(IRQ, 32'h0, "interrupt cleared");
  endtask : test_oneshot
  task automatic test_trig;
    logic [4:0] ctl [4] = '{5'h05, 5'h15, 5'h09, 5'h0D};
    logic [31:0] d0;
    wb(1'b1, 8'h68, 32'h2);
    wb(1'b1, 8'h6C, 32'h1);
    foreach (ctl[i])
    begin
      wb(1'b1, 8'h60, {27'h0, ctl[i]});
      d0 = dma3;
      idle(4);
      if (i == 2)
        vs_level <= 1'b1;
      else
        ev_level[3] <= ~ev_level[3];
      idle(12);
      check(dma3 - d0, {31'h0, i != 3}, "trigger start");
    end
  endtask : test_trig
  initial
  begin
    repeat (16) @(posedge SYS_CLK);
    NRST <= 1'b1;
    test_reset;
    test_idle;
    test_shadow;
    test_oneshot;
    test_trig;
    test_channels;
    print_verdict;
  end
  initial
  begin
    #800000;
    failures++;
    print_verdict;
  end
endmodule : pwm_bank_tb
